// ### core/wide_task_consts.svh
// Purpose: Shared constants for the wide-mode task state checks.
// Assumes: Included by bare name; definitions only.
// Notes: Byte offsets on the register bus are multiples of four.
`ifndef WIDE_TASK_CONSTS_SVH
`define WIDE_TASK_CONSTS_SVH

`define REG_CTRL       8'h00
`define REG_TPTR_LO    8'h04
`define REG_TPTR_HI    8'h08
`define REG_STATUS     8'h0C
`define REG_MASK       8'h10
`define REG_LAST_LO    8'h14
`define REG_LAST_HI    8'h18
`define REG_CAUSE      8'h1C

`define CTRL_WIDE      0
`define CTRL_COMPAT    1

`define ST_XFER_FAULT  0
`define ST_INTERRUPT_RETURN_INSTRUCTION_FAULT  1
`define ST_LOOKUP_DONE 2
`define ST_LOOKUP_ERR  3
`define ST_BITS        4

`define TSS_PRIV_BASE  8'h04
`define TSS_IST_BASE   8'h1C
`define TSS_IOMAP      8'h64
`define TSS_STRIDE     8'h08
`define WORD_STEP      64'h0000_0000_0000_0004
`define CANON_TOP      47

`define SEL_IOMAP      4'h4
`define SEL_IST_FLAG   3

`define CAUSE_NONE     2'h0
`define CAUSE_XFER     2'h1
`define CAUSE_INTERRUPT_RETURN_INSTRUCTION     2'h2

`endif

// ### core/wide_task_pkg.sv
// Purpose: Types shared by the wide-mode task state checks.
// Assumes: The constants header is on the include path.
// Notes: State of each module is one packed struct.
`include "wide_task_consts.svh"

package wide_task_pkg;

    typedef enum logic [1:0] {
        XFER_JMP,
        XFER_CALL,
        XFER_SWINT,
        XFER_INTR
    } xfer_kind_t;

    typedef enum logic [1:0] {
        FETCH_IDLE,
        FETCH_LO,
        FETCH_HI
    } fetch_fsm_t;

    typedef struct packed {
        fetch_fsm_t fsm;
        logic [3:0] sel;
        logic [63:0] base;
        logic [63:0] addr;
        logic [31:0] lo;
        logic rd;
        logic busy;
        logic done;
        logic err;
        logic [63:0] ptr;
    } fetch_state_t;

    typedef struct packed {
        logic wide_mode;
        logic compat_mode;
        logic [63:0] tptr;
        logic [`ST_BITS-1:0] status;
        logic [`ST_BITS-1:0] mask;
        logic [63:0] last_ptr;
        logic [1:0] last_cause;
        logic [1:0] last_kind;
        logic waitreq;
        logic [31:0] rdata;
        logic gp_fault;
        logic [1:0] gp_cause;
        logic task_switch;
        logic irq;
        logic fetch_req;
        logic [3:0] fetch_sel;
        logic lk_valid;
        logic [63:0] lk_ptr;
        logic lk_err;
    } top_state_t;

endpackage

// ### core/tss_fetch_if.sv
// Purpose: Carrier between the checks block and its structure reader.
// Assumes: One clock; all signals sampled on its rising edge.
// Notes: Memory read port is relayed to the top-level pins.
`timescale 1ns/100ps

interface tss_fetch_if;
    logic req;
    logic [3:0] sel;
    logic [63:0] base;
    logic busy;
    logic done;
    logic err;
    logic [63:0] ptr;
    logic mem_rd;
    logic [63:0] mem_addr;
    logic [31:0] mem_rdata;
    logic mem_rvalid;

    modport ctrl (output req, sel, base, mem_rdata, mem_rvalid,
                  input busy, done, err, ptr, mem_rd, mem_addr);
    modport reader (input req, sel, base, mem_rdata, mem_rvalid,
                    output busy, done, err, ptr, mem_rd, mem_addr);
endinterface

// ### core/tss_fetch.sv
// Purpose: Reads one pointer or the bitmap location from the task structure.
// Assumes: Reader holds rd with its address until memory answers it with rvalid.
// Notes: A request while busy is never issued by the owner.
`timescale 1ns/100ps
`include "wide_task_consts.svh"

module tss_fetch (
    input wire logic clock_i,
    input wire logic reset_i,
    tss_fetch_if.reader fif
);
    wide_task_pkg::fetch_state_t s_r, s_nxt;

    // Select 0-2: privilege stack, 4: bitmap, 9-15: stack table entry 1-7
    function automatic logic sel_ok(input logic [3:0] sel);
        sel_ok = (sel < 4'h3) || (sel == `SEL_IOMAP) ||
                 (sel[`SEL_IST_FLAG] && (sel[2:0] != 3'h0));
    endfunction

    function automatic logic [7:0] sel_offset(input logic [3:0] sel);
        if (sel == `SEL_IOMAP) begin
            sel_offset = `TSS_IOMAP;
        end else if (sel[`SEL_IST_FLAG]) begin
            sel_offset = 8'(`TSS_IST_BASE + `TSS_STRIDE * {5'h00, sel[2:0]});
        end else begin
            sel_offset = 8'(`TSS_PRIV_BASE + `TSS_STRIDE * {6'h00, sel[1:0]});
        end
    endfunction

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        case (s_r.fsm)
            wide_task_pkg::FETCH_IDLE: begin
                if (fif.req) begin
                    s_nxt.sel = fif.sel;
                    s_nxt.base = fif.base;
                    if (!sel_ok(fif.sel)) begin
                        s_nxt.done = 1'b1;
                        s_nxt.err = 1'b1;
                        s_nxt.ptr = 64'h0;
                    end else begin
                        s_nxt.addr = fif.base + {56'h0, sel_offset(fif.sel)};
                        s_nxt.rd = 1'b1;
                        s_nxt.busy = 1'b1;
                        s_nxt.fsm = wide_task_pkg::FETCH_LO;
                    end
                end
            end
            wide_task_pkg::FETCH_LO: begin
                if (fif.mem_rvalid) begin
                    if (s_r.sel == `SEL_IOMAP) begin
                        // Offset is the upper half of the final word
                        s_nxt.ptr = s_r.base + {48'h0, fif.mem_rdata[31:16]};
                        s_nxt.err = 1'b0;
                        s_nxt.done = 1'b1;
                        s_nxt.rd = 1'b0;
                        s_nxt.busy = 1'b0;
                        s_nxt.fsm = wide_task_pkg::FETCH_IDLE;
                    end else begin
                        s_nxt.lo = fif.mem_rdata;
                        s_nxt.addr = s_r.addr + `WORD_STEP;
                        s_nxt.fsm = wide_task_pkg::FETCH_HI;
                    end
                end
            end
            wide_task_pkg::FETCH_HI: begin
                if (fif.mem_rvalid) begin
                    s_nxt.ptr = {fif.mem_rdata, s_r.lo};
                    // Upper bits must all copy the top implemented address bit
                    s_nxt.err = !((&fif.mem_rdata[31:`CANON_TOP-32]) ||
                                  (~|fif.mem_rdata[31:`CANON_TOP-32]));
                    s_nxt.done = 1'b1;
                    s_nxt.rd = 1'b0;
                    s_nxt.busy = 1'b0;
                    s_nxt.fsm = wide_task_pkg::FETCH_IDLE;
                end
            end
            default: begin
                s_nxt.fsm = wide_task_pkg::FETCH_IDLE;
                s_nxt.rd = 1'b0;
                s_nxt.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign fif.busy = s_r.busy;
    assign fif.done = s_r.done;
    assign fif.err = s_r.err;
    assign fif.ptr = s_r.ptr;
    assign fif.mem_rd = s_r.rd;
    assign fif.mem_addr = s_r.addr;
endmodule

// ### core/wide_task_checks.sv
// Purpose: Task transfer checks and task structure lookups in 64-bit mode.
// Assumes: Core events are one-cycle pulses on clock_i; Avalon-MM slave.
// Notes: Lookups read memory through the structure reader.
// Operation
// - In 64-bit mode, transfers to a task structure or gate fault instead of switching; the code faults only with compat_mode clear.
// - In 64-bit mode, interrupt return with nested task flag 1 faults; the code faults only with compat_mode clear.
// - Privilege 0-2 stack pointers come from the structure as canonical 64-bit values.
// - Interrupt stack table entries come from the structure as canonical 64-bit values.
// - Bitmap location is structure base plus the 16-bit offset held there.
// - One structure from the task pointer register serves native and compatibility code.
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "wide_task_consts.svh"

module wide_task_checks (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic xfer_valid_i,
    input wire logic [1:0] xfer_kind_i,
    input wire logic xfer_to_task_i,
    input wire logic interrupt_return_instruction_valid_i,
    input wire logic nested_task_flag_i,
    output logic general_protection_fault_o,
    output logic [1:0] fault_cause_o,
    output logic task_switch_o,
    input wire logic lookup_req_i,
    input wire logic [3:0] lookup_sel_i,
    output logic lookup_busy_o,
    output logic lookup_valid_o,
    output logic [63:0] lookup_ptr_o,
    output logic lookup_err_o,
    output logic mem_rd_o,
    output logic [63:0] mem_addr_o,
    input wire logic [31:0] mem_rdata_i,
    input wire logic mem_rvalid_i,
    output logic irq_o
);
    wide_task_pkg::top_state_t s_r, s_nxt;
    tss_fetch_if fif();

    tss_fetch u_fetch (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .fif(fif)
    );

    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            merge_be[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    logic in_wide_native;
    logic xfer_fault;
    logic interrupt_return_instruction_fault;
    logic bus_req;
    logic bus_take;
    logic wr_take;
    logic [`ST_BITS-1:0] ev;
    logic [`ST_BITS-1:0] w1c;

    // Compatibility code keeps its legacy path; the checks cover native 64-bit only
    assign in_wide_native = s_r.wide_mode && !s_r.compat_mode;
    assign xfer_fault = in_wide_native && xfer_valid_i && xfer_to_task_i;
    assign interrupt_return_instruction_fault = in_wide_native && interrupt_return_instruction_valid_i && nested_task_flag_i;
    assign bus_req = avs_read_i || avs_write_i;
    // A request completes at the edge where waitrequest is already low
    assign bus_take = bus_req && !s_r.waitreq;
    assign wr_take = bus_take && avs_write_i;

    always_comb begin
        ev = '0;
        ev[`ST_XFER_FAULT] = xfer_fault;
        ev[`ST_INTERRUPT_RETURN_INSTRUCTION_FAULT] = interrupt_return_instruction_fault;
        ev[`ST_LOOKUP_DONE] = fif.done;
        // Same error as the lookup result, so the status bit and the pin agree
        ev[`ST_LOOKUP_ERR] = fif.done && (fif.err || !s_r.wide_mode);
        w1c = '0;
        if (wr_take && avs_address_i == `REG_STATUS && avs_byteenable_i[0]) begin
            w1c = avs_writedata_i[`ST_BITS-1:0];
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.gp_fault = 1'b0;
        s_nxt.task_switch = 1'b0;
        s_nxt.fetch_req = 1'b0;
        s_nxt.lk_valid = 1'b0;

        if (xfer_fault || interrupt_return_instruction_fault) begin
            s_nxt.gp_fault = 1'b1;
            s_nxt.gp_cause = xfer_fault ? `CAUSE_XFER : `CAUSE_INTERRUPT_RETURN_INSTRUCTION;
            s_nxt.last_cause = s_nxt.gp_cause;
            s_nxt.last_kind = xfer_kind_i;
        end else begin
            // Outside native 64-bit mode a task-bound transfer goes to the legacy switcher
            s_nxt.task_switch = !in_wide_native && xfer_valid_i && xfer_to_task_i;
        end

        // Lookups are refused while one is running; busy tells the core so
        if (lookup_req_i && !fif.busy && !s_r.fetch_req) begin
            s_nxt.fetch_req = 1'b1;
            s_nxt.fetch_sel = lookup_sel_i;
        end
        if (fif.done) begin
            // Outside wide mode there is no structure to trust
            s_nxt.lk_valid = 1'b1;
            s_nxt.lk_ptr = fif.ptr;
            s_nxt.lk_err = fif.err || !s_r.wide_mode;
            s_nxt.last_ptr = fif.ptr;
        end

        // Set wins over a same-cycle clear
        s_nxt.status = (s_r.status & ~w1c) | ev;

        if (wr_take) begin
            case (avs_address_i)
                `REG_CTRL: begin
                    if (avs_byteenable_i[0]) begin
                        s_nxt.wide_mode = avs_writedata_i[`CTRL_WIDE];
                        s_nxt.compat_mode = avs_writedata_i[`CTRL_COMPAT];
                    end
                end
                `REG_TPTR_LO: begin
                    s_nxt.tptr[31:0] =
                        merge_be(s_r.tptr[31:0], avs_writedata_i, avs_byteenable_i);
                end
                `REG_TPTR_HI: begin
                    s_nxt.tptr[63:32] =
                        merge_be(s_r.tptr[63:32], avs_writedata_i, avs_byteenable_i);
                end
                `REG_MASK: begin
                    if (avs_byteenable_i[0]) begin
                        s_nxt.mask = avs_writedata_i[`ST_BITS-1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        if (bus_take) begin
            s_nxt.waitreq = 1'b1;
        end else if (bus_req) begin
            s_nxt.waitreq = 1'b0;
            // Captured a cycle early so readdata is a flop when waitrequest drops
            case (avs_address_i)
                `REG_CTRL: begin
                    s_nxt.rdata = {30'h0, s_r.compat_mode, s_r.wide_mode};
                end
                `REG_TPTR_LO: begin
                    s_nxt.rdata = s_r.tptr[31:0];
                end
                `REG_TPTR_HI: begin
                    s_nxt.rdata = s_r.tptr[63:32];
                end
                `REG_STATUS: begin
                    s_nxt.rdata = {28'h0, s_r.status};
                end
                `REG_MASK: begin
                    s_nxt.rdata = {28'h0, s_r.mask};
                end
                `REG_LAST_LO: begin
                    s_nxt.rdata = s_r.last_ptr[31:0];
                end
                `REG_LAST_HI: begin
                    s_nxt.rdata = s_r.last_ptr[63:32];
                end
                `REG_CAUSE: begin
                    s_nxt.rdata = {28'h0, s_r.last_kind, s_r.last_cause};
                end
                default: begin
                    s_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end

        s_nxt.irq = |(s_nxt.status & s_nxt.mask);
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            s_r <= '0;
            // Bus idles with waitrequest high, so no request completes in its first cycle
            s_r.waitreq <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // The same pointer register serves native and compatibility lookups
    assign fif.req = s_r.fetch_req;
    assign fif.sel = s_r.fetch_sel;
    assign fif.base = s_r.tptr;
    assign fif.mem_rdata = mem_rdata_i;
    assign fif.mem_rvalid = mem_rvalid_i;

    assign avs_readdata_o = s_r.rdata;
    assign avs_waitrequest_o = s_r.waitreq;
    assign general_protection_fault_o = s_r.gp_fault;
    assign fault_cause_o = s_r.gp_cause;
    assign task_switch_o = s_r.task_switch;
    assign lookup_busy_o = fif.busy;
    assign lookup_valid_o = s_r.lk_valid;
    assign lookup_ptr_o = s_r.lk_ptr;
    assign lookup_err_o = s_r.lk_err;
    assign mem_rd_o = fif.mem_rd;
    assign mem_addr_o = fif.mem_addr;
    assign irq_o = s_r.irq;
endmodule

// ### bench/wide_task_checker.sv
// Purpose: Port-level timing checks for the wide-mode task checks.
// Assumes: Mode bits mirrored from accepted lane 0 writes to CTRL.
// Notes: Sees top ports only; attached by bind below.
`timescale 1ns/100ps
module wide_task_checker (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic avs_waitrequest_o,
    input wire logic xfer_valid_i,
    input wire logic xfer_to_task_i,
    input wire logic interrupt_return_instruction_valid_i,
    input wire logic nested_task_flag_i,
    input wire logic general_protection_fault_o,
    input wire logic [1:0] fault_cause_o,
    input wire logic task_switch_o,
    input wire logic lookup_valid_o,
    input wire logic mem_rd_o,
    input wire logic [63:0] mem_addr_o,
    input wire logic mem_rvalid_i
);
    logic [1:0] mode_r;
    logic native;
    logic to_task;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            mode_r <= 2'h0;
        end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h00
                     && avs_byteenable_i[0]) begin
            mode_r <= avs_writedata_i[1:0];
        end
    end
    assign native = mode_r == 2'h1;
    assign to_task = xfer_valid_i && xfer_to_task_i;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("bus access not answered");
    a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    a_xfer_fault: assert property (to_task && native
        |=> general_protection_fault_o && fault_cause_o == 2'h1 && !task_switch_o)
        else $error("task transfer did not fault");
    a_interrupt_return_instruction_fault: assert property (interrupt_return_instruction_valid_i && nested_task_flag_i && native && !to_task
        |=> general_protection_fault_o && fault_cause_o == 2'h2)
        else $error("nested return did not fault");
    a_fault_cause: assert property (general_protection_fault_o
        |-> $past(native && (to_task || interrupt_return_instruction_valid_i && nested_task_flag_i)))
        else $error("fault without cause");
    a_no_switch: assert property (task_switch_o |-> $past(!native))
        else $error("task switch in native mode");
    a_rd_hold: assert property (mem_rd_o && !mem_rvalid_i
        |=> mem_rd_o && $stable(mem_addr_o)) else $error("memory read not held");
    a_word_step: assert property (mem_rd_o && mem_rvalid_i
        |=> !mem_rd_o || mem_addr_o == $past(mem_addr_o) + 64'h4)
        else $error("second word not next address");
    c_interrupt_return_instruction: cover property (general_protection_fault_o && fault_cause_o == 2'h2);
    c_look: cover property (lookup_valid_o);
    c_word: cover property (mem_rd_o && mem_rvalid_i);
endmodule

bind wide_task_checks wide_task_checker chk_u (.clock_i, .reset_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o,
    .xfer_valid_i, .xfer_to_task_i, .interrupt_return_instruction_valid_i, .nested_task_flag_i,
    .general_protection_fault_o, .fault_cause_o, .task_switch_o, .lookup_valid_o,
    .mem_rd_o, .mem_addr_o, .mem_rvalid_i);

// ### bench/testbench.sv
// Purpose: Self-checking bench for the wide-mode task checks.
// Assumes: Bench drives all ports; memory answers after a random stall.
// Notes: Expected results queue up; one watcher compares them.
`timescale 1ns/100ps
module testbench;
    logic clock_i = 0, reset_i = 1, avs_read_i = 0, avs_write_i = 0;
    logic [7:0] avs_address_i = 8'h00;
    logic [31:0] avs_writedata_i = 0, avs_readdata_o, mem_rdata_i = 0, r, tss [0:25];
    logic [3:0] avs_byteenable_i = 4'hF, lookup_sel_i = 4'h0;
    logic xfer_valid_i = 0, xfer_to_task_i = 0, interrupt_return_instruction_valid_i = 0, nested_task_flag_i = 0;
    logic [1:0] xfer_kind_i = 0, fault_cause_o, mode = 0, wt = 0;
    logic lookup_req_i = 0, mem_rvalid_i = 0, avs_waitrequest_o, general_protection_fault_o;
    logic task_switch_o, lookup_busy_o, lookup_valid_o, lookup_err_o, mem_rd_o, irq_o;
    logic [63:0] lookup_ptr_o, mem_addr_o, tptr = 64'h0000_0000_0001_0000;
    integer errors = 0, samples_checked = 0, seed = 72, n, ts_exp = 0, ts_seen = 0;
    logic [31:0] rd_q[$];
    logic [1:0] flt_q[$];
    logic [64:0] lk_q[$];

    wide_task_checks dut_u (.clock_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .xfer_valid_i, .xfer_kind_i, .xfer_to_task_i, .interrupt_return_instruction_valid_i, .nested_task_flag_i,
        .general_protection_fault_o, .fault_cause_o, .task_switch_o, .lookup_req_i,
        .lookup_sel_i, .lookup_busy_o, .lookup_valid_o, .lookup_ptr_o, .lookup_err_o,
        .mem_rd_o, .mem_addr_o, .mem_rdata_i, .mem_rvalid_i, .irq_o);

    initial begin
        forever #4 clock_i = ~clock_i;
    end

    task automatic print_verdict;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic cmp_flt(input logic [1:0] e, input logic [1:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("BAD fault cause exp %h got %h", e, g);
        end
    endtask

    task automatic cmp_lk(input logic [64:0] e);
        logic [64:0] g;
        g = {lookup_err_o, lookup_ptr_o};
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("BAD lookup exp %h got %h", e, g);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) begin
            errors++;
            print_verdict;
        end
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask

    task automatic ev(input logic xv, input logic [1:0] k, input logic tt, input logic iv,
                      input logic nt);
        xfer_valid_i <= xv;
        xfer_kind_i <= k;
        xfer_to_task_i <= tt;
        interrupt_return_instruction_valid_i <= iv;
        nested_task_flag_i <= nt;
        if (mode == 2'h1 && (xv && tt || iv && nt)) begin
            flt_q.push_back(xv && tt ? 2'h1 : 2'h2);
        end
        if (mode != 2'h1 && xv && tt) begin
            ts_exp++;
        end
        @(posedge clock_i);
    endtask

    task automatic look(input logic [3:0] s);
        logic [63:0] p;
        logic ok;
        int o;
        ok = s < 3 || s == 4 || s > 8;
        o = s < 3 ? 1 + 2 * s : (s > 8 ? 2 * s - 9 : 0);
        p = s == 4 ? tptr + tss[25][31:16] : {tss[o + 1], tss[o]};
        lk_q.push_back({!mode[0] || !ok || p[63:47] != {17{p[47]}}, ok ? p : 64'h0});
        lookup_sel_i <= s;
        lookup_req_i <= 1'b1;
        @(posedge clock_i);
        lookup_req_i <= 1'b0;
        n = 0;
        while (lookup_valid_o !== 1'b1 && n < 60) begin
            @(posedge clock_i);
            n++;
            if (n == 2) begin
                cmp_bus("busy", {31'h0, ok}, {31'h0, lookup_busy_o});
            end
        end
        if (n >= 60) begin
            errors++;
            print_verdict;
        end
    endtask

    // Released bus lines toggle each cycle, showing the last word inverted and then the last word again
    always @(posedge clock_i) begin
        if (mem_rd_o === 1'b1 && !mem_rvalid_i && wt == 0) begin
            mem_rvalid_i <= 1'b1;
            mem_rdata_i <= tss[(mem_addr_o - tptr) >> 2];
            wt <= 2'($random(seed));
        end else begin
            mem_rvalid_i <= 1'b0;
            mem_rdata_i <= ~mem_rdata_i;
            wt <= mem_rd_o === 1'b1 && wt != 0 ? wt - 2'h1 : wt;
        end
    end

    always @(posedge clock_i) begin
        if (!reset_i && avs_read_i && avs_waitrequest_o === 1'b0) begin
            cmp_bus("readdata", rd_q.pop_front(), avs_readdata_o);
        end
        if (general_protection_fault_o === 1'b1) begin
            cmp_flt(flt_q.size() > 0 ? flt_q.pop_front() : 2'h0, fault_cause_o);
        end
        if (lookup_valid_o === 1'b1) begin
            cmp_lk(lk_q.pop_front());
        end
        if (task_switch_o === 1'b1) begin
            ts_seen++;
        end
    end

    initial begin
        repeat (20000) @(posedge clock_i);
        errors++;
        print_verdict;
    end

    initial begin
        for (n = 0; n < 26; n++) begin
            tss[n] = $random(seed);
        end
        for (n = 2; n < 24; n += 2) begin
            tss[n][31:15] = {17{tss[n][15]}};
        end
        // Stack table entry 2 made non-canonical
        tss[12][31] = !tss[12][31];
        repeat (6) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        for (int i = 0; i < 9; i++) begin
            rd(8'(4 * i), 32'h0);
        end
        bus(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF);
        rd(8'h20, 32'h0);
        bus(1'b1, 8'h04, 32'hAAAA_BBBB, 4'h3);
        rd(8'h04, 32'h0000_BBBB);
        bus(1'b1, 8'h04, tptr[31:0], 4'hF);
        bus(1'b1, 8'h08, tptr[63:32], 4'hF);
        for (int m = 0; m < 4; m++) begin
            mode = 2'(m);
            bus(1'b1, 8'h00, 32'(m), 4'hF);
            for (int k = 0; k < 4; k++) begin
                ev(1'b1, 2'(k), 1'b1, 1'b0, 1'b0);
            end
            ev(1'b1, 2'h0, 1'b0, 1'b0, 1'b0);
            ev(1'b0, 2'h0, 1'b0, 1'b1, 1'b1);
            ev(1'b0, 2'h0, 1'b0, 1'b1, 1'b0);
            ev(1'b1, 2'h3, 1'b1, 1'b1, 1'b1);
            ev(1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
            if (m == 1) begin
                rd(8'h1C, 32'h0000_000D);
                rd(8'h0C, 32'h0000_0003);
            end
        end
        bus(1'b1, 8'h10, 32'h1, 4'hF);
        repeat (2) @(posedge clock_i);
        cmp_bus("irq", 32'h1, {31'h0, irq_o});
        bus(1'b1, 8'h0C, 32'hF, 4'hF);
        repeat (2) @(posedge clock_i);
        cmp_bus("irq", 32'h0, {31'h0, irq_o});
        rd(8'h0C, 32'h0);
        mode = 2'h1;
        bus(1'b1, 8'h00, 32'h1, 4'hF);
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            ev(r[0], r[2:1], r[3], r[4], r[5]);
        end
        ev(1'b0, 2'h0, 1'b0, 1'b0, 1'b0);
        for (int s = 0; s < 16; s++) begin
            look(4'(s));
        end
        mode = 2'h3;
        bus(1'b1, 8'h00, 32'h3, 4'hF);
        look(4'h1);
        look(4'h4);
        mode = 2'h0;
        bus(1'b1, 8'h00, 32'h0, 4'hF);
        look(4'h0);
        repeat (4) @(posedge clock_i);
        cmp_bus("pending", 32'h0, 32'(flt_q.size() + lk_q.size()));
        cmp_bus("task switches", 32'(ts_exp), 32'(ts_seen));
        print_verdict;
    end
endmodule
